/* File: fppc_pkg.sv */
// fppc_pkg: register offsets, field positions, reset values and timing
// constants shared by the flash program/protect controller.
// assumes a 20 MHz system clock and a 32-bit plain register port.
package fppc_pkg;
    // flash control space offsets
    localparam logic [11:0] OFS_OP_ADDRESS = 12'h000;
    localparam logic [11:0] OFS_OP_WRITE_DATA = 12'h004;
    localparam logic [11:0] OFS_OP_CONTROL = 12'h008;
    localparam logic [11:0] OFS_IRQ_RAW_STATUS = 12'h00C;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h010;
    localparam logic [11:0] OFS_IRQ_MASKED_CLEAR = 12'h014;
    // system control space offsets
    localparam logic [11:0] OFS_READ_PROTECT = 12'h130;
    localparam logic [11:0] OFS_PROGRAM_PROTECT = 12'h134;
    localparam logic [11:0] OFS_MICROSECOND_RELOAD = 12'h140;

    // op_control fields
    localparam logic [15:0] WRITE_KEY = 16'hA442;
    localparam int KEY_LSB = 16;
    localparam int CTL_WRITE = 0;
    localparam int CTL_ERASE = 1;
    localparam int CTL_WHOLE_ERASE = 2;
    localparam int CTL_COMMIT = 3;

    // interrupt status fields
    localparam int IRQ_ACCESS = 0;
    localparam int IRQ_DONE = 1;

    // reset values
    localparam logic [7:0] USEC_RESET = 8'h31;
    localparam logic [15:0] PROT_RESET = 16'hFFFF;

    // address layout of a 15-bit flash byte offset
    localparam int OFFSET_W = 15;
    localparam int WORD_LSB = 2;
    localparam int PAGE_LSB = 10;
    localparam int REGION_LSB = 11;
    localparam int REGIONS = 16;
    localparam int PAGE_WORDS = 256;

    // timing in microseconds
    localparam int CLK_MHZ = 20;
    localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
    localparam int COMMIT_US = 50;
    localparam int PROGRAM_US = 20;
    localparam int PAGE_ERASE_US = 100;
    localparam int WHOLE_ERASE_US = 200;

    typedef enum logic [1:0] {OP_PROGRAM, OP_PAGE_ERASE, OP_WHOLE_ERASE, OP_COMMIT} fppc_op_t;
    typedef enum {ST_IDLE, ST_WAIT, ST_SWEEP} fppc_state_t;
endpackage : fppc_pkg

/* File: fppc_ctrl.sv */
// fppc_ctrl: flash array, erase/program sequencer, 2 KB protection and
// commit, microsecond tick divider, violation status.
// assumes software drives the plain register port; one clock, sync reset.
// Operation
// RULE_01 - erase clears a selected 1 KB page to all ones
// RULE_02 - each protection bit covers one 2 KB region
// RULE_03 - execute-only regions serve instruction fetches only
// RULE_04 - internal timing counts clock cycles per microsecond, reload is MHz minus one
// RULE_05 - reload count resets to 0x31; software reloads it after clock changes
// RULE_06 - program-enable one allows write/erase; zero refuses any change
// RULE_07 - read-enable zero blocks data access, fetch still allowed
// RULE_08 - program-enable one, read-enable zero: write, erase, execute, no data read
// RULE_09 - program/erase on protected region blocked; masked violation raises interrupt
// RULE_10 - blocked data read returns all zeros
// RULE_11 - protection leaves factory all ones; uncommitted clears undone by power-on
// RULE_12 - edited protection bits take effect before commit
// RULE_13 - software selects commit target with address bit 0, then sets commit
// RULE_14 - program: data, address, then 0xA4420001; write bit clears when done
// RULE_15 - page erase: address, then 0xA4420002; erase bit clears when done
// RULE_16 - whole erase: 0xA4420004; whole-erase bit clears when done
// RULE_17 - raw status read-only, mask read/write, masked status write-one-clear
// RULE_18 - software doing erase/program runs from SRAM
// RULE_19 - control writes without key 0xA442 ignored; key reads zero
// RULE_20 - protection bits only go one to zero by software
// RULE_21 - commit bit reads one while busy, zero when done; up to 50 us
// RULE_22 - address register holds 15-bit offset in bits 14:0
// RULE_23 - two register regions: flash control space and system control space
//
// The implementer's own choice: strobed register access.
module fppc_ctrl
    import fppc_pkg::*;
#(
    parameter int WORDS = 8192,
    parameter int COMMIT_TICKS = COMMIT_US,
    parameter int PROGRAM_TICKS = PROGRAM_US,
    parameter int PAGE_ERASE_TICKS = PAGE_ERASE_US,
    parameter int WHOLE_ERASE_TICKS = WHOLE_ERASE_US
)
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic factory_init_in,
    // register port
    input wire logic [11:0] reg_addr_in,
    input wire logic reg_sysctl_sel_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // instruction fetch port
    input wire logic fetch_in,
    input wire logic [OFFSET_W-1:0] fetch_addr_in,
    output logic [31:0] fetch_data_out,
    // data-side bus read port
    input wire logic data_rd_in,
    input wire logic [OFFSET_W-1:0] data_addr_in,
    output logic [31:0] data_rdata_out,
    output logic data_blocked_out,
    // status
    output logic irq_out,
    output logic busy_out
);
    localparam int IDX_W = $clog2(WORDS);

    function automatic logic [3:0] region_of(input logic [OFFSET_W-1:0] a);
        region_of = a[REGION_LSB +: 4]; // RULE_02
    endfunction : region_of

    function automatic logic [IDX_W-1:0] word_of(input logic [OFFSET_W-1:0] a);
        word_of = a[WORD_LSB +: IDX_W];
    endfunction : word_of

    logic [31:0] mem [WORDS];
    logic [OFFSET_W-1:0] op_address_q;
    logic [31:0] op_write_data_q;
    logic [3:0] ctl_bits_q;
    logic [1:0] irq_raw_q;
    logic [1:0] irq_mask_q;
    logic [15:0] rprot_q;
    logic [15:0] pprot_q;
    logic [15:0] nv_rprot_q;
    logic [15:0] nv_pprot_q;
    logic [7:0] usec_q;
    logic [7:0] tick_cnt_q;
    logic [15:0] us_left_q;
    logic [IDX_W-1:0] sweep_q;
    logic [IDX_W-1:0] sweep_end_q;
    fppc_op_t op_q;
    fppc_state_t state_q;
    logic [31:0] reg_rdata_q;
    logic [31:0] fetch_data_q;
    logic [31:0] data_rdata_q;
    logic data_blocked_q;
    logic irq_q;
    logic busy_q;

    // register decode, two spaces
    wire fc_space = !reg_sysctl_sel_in; // RULE_23
    wire wr_fc = reg_wr_in && fc_space;
    wire wr_sc = reg_wr_in && reg_sysctl_sel_in;
    wire wr_addr = wr_fc && reg_addr_in == OFS_OP_ADDRESS;
    wire wr_data = wr_fc && reg_addr_in == OFS_OP_WRITE_DATA;
    wire wr_ctl = wr_fc && reg_addr_in == OFS_OP_CONTROL;
    wire wr_mask = wr_fc && reg_addr_in == OFS_IRQ_MASK;
    wire wr_clr = wr_fc && reg_addr_in == OFS_IRQ_MASKED_CLEAR;
    wire wr_rprot = wr_sc && reg_addr_in == OFS_READ_PROTECT;
    wire wr_pprot = wr_sc && reg_addr_in == OFS_PROGRAM_PROTECT;
    wire wr_usec = wr_sc && reg_addr_in == OFS_MICROSECOND_RELOAD;

    // control write qualification
    wire key_ok = reg_wdata_in[31:KEY_LSB] == WRITE_KEY; // RULE_19
    wire idle = state_q == ST_IDLE;
    wire ctl_go = wr_ctl && key_ok && idle;
    wire [3:0] op_region = region_of(op_address_q);
    wire target_open = pprot_q[op_region]; // RULE_06 RULE_12
    wire all_open = &pprot_q;
    // multiple control bits: write, else erase, wins if set; otherwise nothing starts, a programming error anyway
    wire go_prog = ctl_go && reg_wdata_in[CTL_WRITE];
    wire go_erase = ctl_go && !reg_wdata_in[CTL_WRITE] && reg_wdata_in[CTL_ERASE];
    wire go_whole = ctl_go && reg_wdata_in[3:0] == 4'b0100;
    wire go_commit = ctl_go && reg_wdata_in[3:0] == 4'b1000;
    wire prog_refused = (go_prog || go_erase) && !target_open; // RULE_09
    wire whole_refused = go_whole && !all_open; // RULE_09
    wire start_ok = (go_prog || go_erase) && target_open || go_whole && all_open || go_commit;

    // data read check
    wire data_open = rprot_q[region_of(data_addr_in)]; // RULE_07 RULE_12
    wire read_refused = data_rd_in && !data_open;

    // microsecond tick
    wire tick = tick_cnt_q == 8'h00; // RULE_04
    wire wait_done = state_q == ST_WAIT && tick && us_left_q == 16'h0001;
    wire sweep_done = state_q == ST_SWEEP && sweep_q == sweep_end_q;

    // interrupt status, set wins over clear
    wire [1:0] irq_set = {wait_done && op_q != OP_COMMIT || sweep_done,
                          prog_refused || whole_refused || read_refused};
    wire [1:0] irq_clr = wr_clr ? reg_wdata_in[1:0] : 2'b00;
    wire [1:0] irq_raw_d = (irq_raw_q & ~irq_clr) | irq_set; // RULE_17
    wire [1:0] irq_masked = irq_raw_q & irq_mask_q;

    wire [15:0] op_ticks =
        go_prog ? 16'(PROGRAM_TICKS) :
        go_erase ? 16'(PAGE_ERASE_TICKS) :
        go_whole ? 16'(WHOLE_ERASE_TICKS) : 16'(COMMIT_TICKS);
    wire [IDX_W-1:0] page_first = word_of({op_address_q[OFFSET_W-1:PAGE_LSB], 10'h000});

    // read mux
    wire [31:0] rd_mux =
        !fc_space && reg_addr_in == OFS_READ_PROTECT ? {16'h0000, rprot_q} :
        !fc_space && reg_addr_in == OFS_PROGRAM_PROTECT ? {16'h0000, pprot_q} :
        !fc_space && reg_addr_in == OFS_MICROSECOND_RELOAD ? {24'h00_0000, usec_q} :
        fc_space && reg_addr_in == OFS_OP_ADDRESS ? {17'h0_0000, op_address_q} :
        fc_space && reg_addr_in == OFS_OP_WRITE_DATA ? op_write_data_q :
        fc_space && reg_addr_in == OFS_OP_CONTROL ? {28'h000_0000, ctl_bits_q} :
        fc_space && reg_addr_in == OFS_IRQ_RAW_STATUS ? {30'h0000_0000, irq_raw_q} :
        fc_space && reg_addr_in == OFS_IRQ_MASK ? {30'h0000_0000, irq_mask_q} :
        fc_space && reg_addr_in == OFS_IRQ_MASKED_CLEAR ? {30'h0000_0000, irq_masked} :
        32'h0000_0000;

    // software registers
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            op_address_q <= '0;
            op_write_data_q <= '0;
            irq_mask_q <= '0;
            irq_raw_q <= '0;
            usec_q <= USEC_RESET; // RULE_05
        end
        else
        begin
            if (wr_addr)
                op_address_q <= reg_wdata_in[OFFSET_W-1:0]; // RULE_22
            if (wr_data)
                op_write_data_q <= reg_wdata_in;
            if (wr_mask)
                irq_mask_q <= reg_wdata_in[1:0];
            if (wr_usec)
                usec_q <= reg_wdata_in[7:0];
            irq_raw_q <= irq_raw_d;
        end
    end

    // live protection, restored from committed copy at power-on
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            rprot_q <= factory_init_in ? PROT_RESET : nv_rprot_q; // RULE_11
            pprot_q <= factory_init_in ? PROT_RESET : nv_pprot_q; // RULE_11
        end
        else
        begin
            if (wr_rprot)
                rprot_q <= rprot_q & reg_wdata_in[15:0]; // RULE_20
            if (wr_pprot)
                pprot_q <= pprot_q & reg_wdata_in[15:0]; // RULE_20
        end
    end

    // nonvolatile copy: untouched by reset, so it survives power cycles
    always_ff @(posedge sys_clk_in)
    begin
        if (factory_init_in)
        begin
            nv_rprot_q <= PROT_RESET; // RULE_11
            nv_pprot_q <= PROT_RESET;
        end
        else if (wait_done && op_q == OP_COMMIT)
        begin
            if (op_address_q[0])
                nv_pprot_q <= pprot_q; // RULE_13
            else
                nv_rprot_q <= rprot_q;
        end
    end

    // tick divider, restarted on each operation for a full first microsecond
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            tick_cnt_q <= USEC_RESET;
        else if (tick || start_ok)
            tick_cnt_q <= usec_q; // RULE_04
        else
            tick_cnt_q <= tick_cnt_q - 8'h01;
    end

    // sequencer
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            state_q <= ST_IDLE;
            op_q <= OP_PROGRAM;
            ctl_bits_q <= '0;
            busy_q <= 1'b0;
            us_left_q <= '0;
            sweep_q <= '0;
            sweep_end_q <= '0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (start_ok)
                    begin
                        state_q <= ST_WAIT;
                        busy_q <= 1'b1;
                        us_left_q <= op_ticks;
                        ctl_bits_q <= reg_wdata_in[3:0] & {go_commit, go_whole, go_erase, go_prog}; // RULE_21
                        op_q <= go_prog ? OP_PROGRAM : go_erase ? OP_PAGE_ERASE :
                                go_whole ? OP_WHOLE_ERASE : OP_COMMIT;
                        sweep_q <= go_whole ? '0 : page_first;
                        sweep_end_q <= go_whole ? IDX_W'(WORDS - 1) :
                                       page_first + IDX_W'(PAGE_WORDS - 1);
                    end
                end
                ST_WAIT:
                begin
                    if (tick)
                        us_left_q <= us_left_q - 16'h0001;
                    if (wait_done)
                    begin
                        if (op_q == OP_PAGE_ERASE || op_q == OP_WHOLE_ERASE)
                            state_q <= ST_SWEEP;
                        else
                        begin
                            state_q <= ST_IDLE;
                            ctl_bits_q <= '0; // RULE_14 RULE_21
                            busy_q <= 1'b0;
                        end
                    end
                end
                ST_SWEEP:
                begin
                    sweep_q <= sweep_q + IDX_W'(1);
                    if (sweep_done)
                    begin
                        state_q <= ST_IDLE;
                        ctl_bits_q <= '0; // RULE_15 RULE_16
                        busy_q <= 1'b0;
                    end
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // array: programming can only clear bits, erase sets them
    always_ff @(posedge sys_clk_in)
    begin
        if (wait_done && op_q == OP_PROGRAM)
            mem[word_of(op_address_q)] <= mem[word_of(op_address_q)] & op_write_data_q; // RULE_14
        else if (state_q == ST_SWEEP)
            mem[sweep_q] <= 32'hFFFF_FFFF; // RULE_01
    end

    // read ports and outputs
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            reg_rdata_q <= '0;
            fetch_data_q <= '0;
            data_rdata_q <= '0;
            data_blocked_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            reg_rdata_q <= reg_rd_in ? rd_mux : 32'h0000_0000;
            if (fetch_in)
                fetch_data_q <= mem[word_of(fetch_addr_in)]; // RULE_03
            if (data_rd_in)
                data_rdata_q <= data_open ? mem[word_of(data_addr_in)] : 32'h0000_0000; // RULE_10
            data_blocked_q <= read_refused; // RULE_08
            irq_q <= |irq_masked; // RULE_09
        end
    end

    assign reg_rdata_out = reg_rdata_q;
    assign fetch_data_out = fetch_data_q;
    assign data_rdata_out = data_rdata_q;
    assign data_blocked_out = data_blocked_q;
    assign irq_out = irq_q;
    assign busy_out = busy_q;

    // commit length bound in a counter: a delay range that long is too slow to check
    localparam int COMMIT_MAX_CYC = COMMIT_TICKS * 256 + 2;
    logic [15:0] commit_cyc_q;
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in || !ctl_bits_q[CTL_COMMIT])
            commit_cyc_q <= 16'h0000;
        else
            commit_cyc_q <= commit_cyc_q + 16'h0001;
    end

    a_key_guard: assert property ( // RULE_19
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        wr_ctl && !key_ok && idle |=> $stable(ctl_bits_q) && $stable(state_q))
        else $error("control write without key changed state");

    a_prog_blocked: assert property ( // RULE_09
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        prog_refused |=> ctl_bits_q == 4'h0 && irq_raw_q[IRQ_ACCESS])
        else $error("program on protected region not refused");

    a_read_zero: assert property ( // RULE_10
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        read_refused |=> data_rdata_out == 32'h0000_0000 && data_blocked_out)
        else $error("blocked data read leaked data");

    a_prot_one_way: assert property ( // RULE_20
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        ##1 (rprot_q & ~$past(rprot_q)) == 16'h0000 && (pprot_q & ~$past(pprot_q)) == 16'h0000)
        else $error("protection bit went from zero to one");

    a_commit_busy: assert property ( // RULE_21
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        go_commit |=> ctl_bits_q[CTL_COMMIT])
        else $error("commit bit timing wrong");

    a_commit_bound: assert property ( // RULE_21
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        int'(commit_cyc_q) < COMMIT_MAX_CYC)
        else $error("commit bit stuck high too long");

    a_violation_irq: assert property ( // RULE_09
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (prog_refused || whole_refused) && irq_mask_q[IRQ_ACCESS] && !wr_mask |=> ##1 irq_out)
        else $error("masked violation did not raise interrupt");

    a_usec_default: assert property ( // RULE_05
        @(posedge sys_clk_in)
        $rose(rst_n_in) |-> usec_q == USEC_RESET)
        else $error("reload count not at reset value");

    a_tick_period: assert property ( // RULE_04
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        tick && usec_q >= 8'h02 && !start_ok && !wr_usec |=> !tick [*2])
        else $error("microsecond tick too early");

    a_clear_w1c: assert property ( // RULE_17
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        wr_clr && reg_wdata_in[IRQ_DONE] && !irq_set[IRQ_DONE] |=> !irq_raw_q[IRQ_DONE])
        else $error("write-one clear did not clear done bit");
endmodule : fppc_ctrl

/* File: fppc_cpu_model.sv */
// fppc_cpu_model: software side of the register port, run from sram.
// assumes it is called just after a rising edge of sys_clk_in.
module fppc_cpu_model
    import fppc_pkg::*;
(
    // clock
    input wire logic sys_clk_in,
    // register port
    input wire logic [31:0] reg_rdata_in,
    output logic [11:0] reg_addr_out,
    output logic reg_sysctl_sel_out,
    output logic [31:0] reg_wdata_out,
    output logic reg_wr_out,
    output logic reg_rd_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        reg_addr_out = 12'h000;
        reg_sysctl_sel_out = 1'b0;
        reg_wdata_out = 32'h0000_0000;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
    end

    task automatic wr(input logic sel, input logic [11:0] addr, input logic [31:0] data);
        @(posedge sys_clk_in);
        reg_sysctl_sel_out <= sel;
        reg_addr_out <= addr;
        reg_wdata_out <= data;
        reg_wr_out <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr_out <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic sel, input logic [11:0] addr, output logic [31:0] data);
        @(posedge sys_clk_in);
        reg_sysctl_sel_out <= sel;
        reg_addr_out <= addr;
        reg_rd_out <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd_out <= 1'b0;
        #1;
        data = reg_rdata_in;
    endtask : rd

    // key plus one control bit, then poll until that bit clears
    task automatic op(input logic [3:0] bits, output logic [31:0] first);
        logic [31:0] v;
        wr(1'b0, OFS_OP_CONTROL, {WRITE_KEY, 12'h000, bits});
        rd(1'b0, OFS_OP_CONTROL, first);
        v = first;
        // no local limit: a hang is caught by the bench watchdog and fails the run
        while ((v[3:0] & bits) !== 4'h0)
        begin
            rd(1'b0, OFS_OP_CONTROL, v);
        end
    endtask : op
endmodule : fppc_cpu_model

/* File: fppc_ctrl_bench.sv */
// fppc_ctrl_bench: self-checking bench for fppc_ctrl with short op times.
// assumes fppc_pkg and fppc_cpu_model; reload set to 1, two cycles a tick.
module fppc_ctrl_bench
    import fppc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WORDS = 8192;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic factory_init_in = 1'b1;
    logic fetch_in = 1'b0;
    logic [OFFSET_W-1:0] fetch_addr_in = '0;
    logic data_rd_in = 1'b0;
    logic [OFFSET_W-1:0] data_addr_in = '0;
    logic [11:0] reg_addr;
    logic reg_sel;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata_out;
    logic [31:0] fetch_data_out;
    logic [31:0] data_rdata_out;
    logic data_blocked_out;
    logic irq_out;
    logic busy_out;
    int n_mismatch = 0;
    int num_checks = 0;
    int seed = 8072;
    logic [31:0] v;
    logic [31:0] d;
    logic [31:0] d2;
    logic [14:0] a;
    logic blk;

    always #25 sys_clk_in = ~sys_clk_in;

    fppc_cpu_model i_fppc_cpu_model (.sys_clk_in(sys_clk_in), .reg_rdata_in(reg_rdata_out),
        .reg_addr_out(reg_addr), .reg_sysctl_sel_out(reg_sel), .reg_wdata_out(reg_wdata),
        .reg_wr_out(reg_wr), .reg_rd_out(reg_rd));

    fppc_ctrl #(.WORDS(WORDS), .COMMIT_TICKS(3), .PROGRAM_TICKS(2), .PAGE_ERASE_TICKS(3),
        .WHOLE_ERASE_TICKS(3)) i_fppc_ctrl (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .factory_init_in(factory_init_in), .reg_addr_in(reg_addr), .reg_sysctl_sel_in(reg_sel),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(reg_rdata_out), .fetch_in(fetch_in), .fetch_addr_in(fetch_addr_in),
        .fetch_data_out(fetch_data_out), .data_rd_in(data_rd_in), .data_addr_in(data_addr_in),
        .data_rdata_out(data_rdata_out), .data_blocked_out(data_blocked_out),
        .irq_out(irq_out), .busy_out(busy_out));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    // instruction fetch or data-side read, answer in the next cycle
    task automatic mem_rd(input logic fetch, input logic [14:0] addr, output logic [31:0] data,
        output logic blocked);
        @(posedge sys_clk_in);
        fetch_in <= fetch;
        fetch_addr_in <= addr;
        data_rd_in <= ~fetch;
        data_addr_in <= addr;
        @(posedge sys_clk_in);
        fetch_in <= 1'b0;
        data_rd_in <= 1'b0;
        #1;
        data = fetch ? fetch_data_out : data_rdata_out;
        blocked = data_blocked_out;
    endtask : mem_rd

    task automatic do_reset(input logic factory);
        @(posedge sys_clk_in);
        factory_init_in <= factory;
        rst_n_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        factory_init_in <= 1'b0;
    endtask : do_reset

    function automatic logic [31:0] prot_after(input logic [31:0] old, input logic [31:0] w);
        return {16'h0000, old[15:0] & w[15:0]};
    endfunction : prot_after

    task automatic rd_chk(input logic sel, input logic [11:0] addr, input logic [31:0] exp);
        logic [31:0] r;
        i_fppc_cpu_model.rd(sel, addr, r);
        check(r, exp);
    endtask : rd_chk

    initial
    begin
        #(30000 * 50);
        n_mismatch++;
        print_verdict();
    end

    initial
    begin
        do_reset(1'b1);
        rd_chk(1'b1, OFS_MICROSECOND_RELOAD, 32'h0000_0031);
        rd_chk(1'b1, OFS_READ_PROTECT, 32'h0000_FFFF);
        rd_chk(1'b1, OFS_PROGRAM_PROTECT, 32'h0000_FFFF);
        rd_chk(1'b0, OFS_OP_CONTROL, 32'h0000_0000);
        rd_chk(1'b0, OFS_IRQ_RAW_STATUS, 32'h0000_0000);
        rd_chk(1'b0, 12'h020, 32'h0000_0000);
        i_fppc_cpu_model.wr(1'b1, OFS_MICROSECOND_RELOAD, 32'h0000_0001);
        rd_chk(1'b1, OFS_MICROSECOND_RELOAD, 32'h0000_0001);
        // wrong key must leave the sequencer idle
        i_fppc_cpu_model.wr(1'b0, OFS_OP_CONTROL, 32'h1234_0004);
        #1;
        check({31'h0, busy_out}, 32'h0000_0000);
        i_fppc_cpu_model.op(4'h4, v);
        check(v, 32'h0000_0004);
        a = 15'(({$random(seed)} % 256) * 4);
        d = $random(seed);
        mem_rd(1'b0, 15'(({$random(seed)} % WORDS) * 4), v, blk);
        check(v, 32'hFFFF_FFFF);
        i_fppc_cpu_model.wr(1'b0, OFS_OP_WRITE_DATA, d);
        i_fppc_cpu_model.wr(1'b0, OFS_OP_ADDRESS, {17'h1FFFF, a});
        rd_chk(1'b0, OFS_OP_ADDRESS, {17'h0, a});
        i_fppc_cpu_model.op(4'h1, v);
        check(v, 32'h0000_0001);
        mem_rd(1'b0, a, v, blk);
        check(v, d);
        i_fppc_cpu_model.op(4'h2, v);
        check(v, 32'h0000_0002);
        mem_rd(1'b0, a ^ 15'h03FC, v, blk);
        check(v, 32'hFFFF_FFFF);
        mem_rd(1'b0, a, v, blk);
        check(v, 32'hFFFF_FFFF);
        i_fppc_cpu_model.op(4'h1, v);
        i_fppc_cpu_model.wr(1'b0, OFS_IRQ_MASK, 32'h0000_0003);
        i_fppc_cpu_model.wr(1'b0, OFS_IRQ_MASKED_CLEAR, 32'h0000_0003);
        rd_chk(1'b0, OFS_IRQ_RAW_STATUS, 32'h0000_0000);
        i_fppc_cpu_model.wr(1'b0, OFS_IRQ_MASK, 32'h0000_0001);
        rd_chk(1'b0, OFS_IRQ_MASK, 32'h0000_0001);
        // region 0 becomes program-open but data-blind, still volatile
        i_fppc_cpu_model.wr(1'b1, OFS_READ_PROTECT, 32'h0000_FFFE);
        mem_rd(1'b0, a, v, blk);
        check(v, 32'h0000_0000);
        check({31'h0, blk}, 32'h0000_0001);
        mem_rd(1'b0, a + 15'h0800, v, blk);
        check({31'h0, blk}, 32'h0000_0000);
        mem_rd(1'b1, a, v, blk);
        check(v, d);
        check({31'h0, irq_out}, 32'h0000_0001);
        i_fppc_cpu_model.wr(1'b0, OFS_IRQ_MASKED_CLEAR, 32'h0000_0001);
        // irq_out is registered from the masked status: one more edge to drop
        @(posedge sys_clk_in);
        #1;
        check({31'h0, irq_out}, 32'h0000_0000);
        i_fppc_cpu_model.wr(1'b1, OFS_READ_PROTECT, 32'h0000_FFFF);
        rd_chk(1'b1, OFS_READ_PROTECT, prot_after(32'h0000_FFFE, 32'h0000_FFFF));
        d2 = $random(seed);
        i_fppc_cpu_model.wr(1'b0, OFS_OP_WRITE_DATA, d2);
        i_fppc_cpu_model.op(4'h1, v);
        mem_rd(1'b1, a, v, blk);
        check(v, d & d2);
        // region 1 locked: page erase there is refused and flagged
        i_fppc_cpu_model.wr(1'b1, OFS_PROGRAM_PROTECT, 32'h0000_FFFD);
        i_fppc_cpu_model.wr(1'b0, OFS_OP_ADDRESS, 32'h0000_0800);
        i_fppc_cpu_model.op(4'h2, v);
        check(v, 32'h0000_0000);
        check({31'h0, irq_out}, 32'h0000_0001);
        rd_chk(1'b0, OFS_IRQ_MASKED_CLEAR, 32'h0000_0001);
        i_fppc_cpu_model.wr(1'b0, OFS_IRQ_MASKED_CLEAR, 32'h0000_0001);
        i_fppc_cpu_model.wr(1'b0, OFS_OP_ADDRESS, 32'h0000_0001);
        i_fppc_cpu_model.op(4'h8, v);
        check(v, 32'h0000_0008);
        rd_chk(1'b0, OFS_OP_CONTROL, 32'h0000_0000);
        do_reset(1'b0);
        rd_chk(1'b1, OFS_PROGRAM_PROTECT, 32'h0000_FFFD);
        rd_chk(1'b1, OFS_READ_PROTECT, 32'h0000_FFFF);
        rd_chk(1'b0, OFS_IRQ_RAW_STATUS, 32'h0000_0000);
        print_verdict();
    end
endmodule : fppc_ctrl_bench
